// ### hw/cpregs.sv
// Fault status, fault address and maintenance command registers.
// Assumes a core issuing register transfers on MCLK; cache and TLB
// logic act on the one-cycle command pulses; a drain only stalls until WB_EMPTY.
`timescale 1ns/1ns
`default_nettype none
`include "cpregs_defines.svh"

module cpregs
  import cpregs_pkg::*;
#(
  parameter int IDX_LSB = `IDX_LSB_DEF,
  parameter int IDX_W   = `IDX_W_DEF,
  parameter int SEG_LSB = `SEG_LSB_DEF,
  parameter int SEG_W   = `SEG_W_DEF
) (
  // Clock, reset, enable
  input  wire logic              MCLK,
  input  wire logic              NRST,
  input  wire logic              CE,
  // Register transfer port
  input  wire logic              CP_WR,
  input  wire logic              CP_RD,
  input  wire logic [3:0]        CP_CRN,
  input  wire logic [3:0]        CP_SEC,
  input  wire logic [2:0]        CP_OP2,
  input  wire logic [31:0]       CP_WDATA,
  output logic      [31:0]       CP_RDATA,
  output logic                   CP_STALL,
  output logic                   LOW_POWER,
  // Abort reports
  input  wire logic              DABORT,
  input  wire logic [3:0]        DABORT_DOMAIN,
  input  wire logic [3:0]        DABORT_TYPE,
  input  wire logic [31:0]       DABORT_ADDR,
  input  wire logic              PABORT,
  input  wire logic [3:0]        PABORT_DOMAIN,
  input  wire logic [3:0]        PABORT_TYPE,
  // Wake and drain conditions
  input  wire logic              IRQ_PIN,
  input  wire logic              WB_EMPTY,
  // Cache commands
  output logic                   ICACHE_INV_ALL,
  output logic                   DCACHE_INV_ALL,
  output logic                   ICACHE_INV_LINE,
  output logic                   DCACHE_INV_LINE,
  output logic                   DCACHE_CLEAN,
  output logic                   DCACHE_CLEAN_INV,
  output logic                   ICACHE_PREFETCH,
  output logic                   LINE_BY_INDEX,
  output logic      [31:0]       LINE_ADDR,
  output logic      [IDX_W-1:0]  LINE_INDEX,
  output logic      [SEG_W-1:0]  LINE_SEGMENT,
  // TLB commands
  output logic                   ITLB_INV_UNPRESERVED,
  output logic                   DTLB_INV_UNPRESERVED,
  output logic                   ITLB_INV_ADDR,
  output logic                   DTLB_INV_ADDR,
  // TLB entry loading
  input  wire logic              ITLB_FILL,
  input  wire logic              DTLB_FILL,
  input  wire logic              ITLB_PRESERVE_BIT,
  input  wire logic              DTLB_PRESERVE_BIT,
  output logic                   ITLB_FILL_PRESERVED,
  output logic                   DTLB_FILL_PRESERVED
);

  // ==========================================================
  // Command decode
  function automatic cmd_t decode(input logic [3:0] crn,
                                  input logic [3:0] sec,
                                  input logic [2:0] op2);
    cmd_t c;
    c = CMD_NONE;
    if (crn == `CRN_CACHE_CMD) begin
      case ({sec, op2})
        {`SEC_C7,  `OP2_0}: c = CMD_INV_BOTH_CACHE;
        {`SEC_C5,  `OP2_0}: c = CMD_INV_ICACHE;
        {`SEC_C6,  `OP2_0}: c = CMD_INV_DCACHE;
        {`SEC_C5,  `OP2_1}: c = CMD_INV_ILINE;
        {`SEC_C6,  `OP2_1}: c = CMD_INV_DLINE;
        {`SEC_C10, `OP2_1}: c = CMD_CLEAN_ADDR;
        {`SEC_C10, `OP2_2}: c = CMD_CLEAN_IDX;
        {`SEC_C14, `OP2_1}: c = CMD_CLEANINV_ADDR;
        {`SEC_C14, `OP2_2}: c = CMD_CLEANINV_IDX;
        {`SEC_C13, `OP2_1}: c = CMD_PREFETCH;
        {`SEC_C10, `OP2_4}: c = CMD_DRAIN;
        {`SEC_C0,  `OP2_4}: c = CMD_WAIT_IRQ;
        default:            c = CMD_NONE;
      endcase
    end else if (crn == `CRN_TLB_CMD) begin
      // Undefined encodings fall through as no operation
      case ({sec, op2})
        {`SEC_C7, `OP2_0}: c = CMD_INV_BOTH_TLB;
        {`SEC_C5, `OP2_0}: c = CMD_INV_ITLB;
        {`SEC_C6, `OP2_0}: c = CMD_INV_DTLB;
        {`SEC_C5, `OP2_1}: c = CMD_INV_ITLB_ADDR;
        {`SEC_C6, `OP2_1}: c = CMD_INV_DTLB_ADDR;
        default:           c = CMD_NONE;
      endcase
    end
    return c;
  endfunction

  function automatic logic is_index(input cmd_t c);
    return (c == CMD_CLEAN_IDX) || (c == CMD_CLEANINV_IDX);
  endfunction

  // ==========================================================
  // Interrupt synchroniser
  logic irq_meta_r;
  logic irq_sync_r;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      irq_meta_r <= 1'b0;
      irq_sync_r <= 1'b0;
    end else if (CE) begin
      irq_meta_r <= IRQ_PIN;
      irq_sync_r <= irq_meta_r;
    end
  end

  // ==========================================================
  // Register state
  logic [`FST_WIDTH-1:0] dfsr_r;
  logic [`FST_WIDTH-1:0] dfsr_nxt;
  logic [`FST_WIDTH-1:0] pfsr_r;
  logic [`FST_WIDTH-1:0] pfsr_nxt;
  logic [31:0]           far_r;
  logic [31:0]           far_nxt;
  logic [31:0]           rdata_r;
  logic [31:0]           rdata_nxt;
  cmd_t                  cmd_r;
  cmd_t                  cmd_nxt;
  logic [31:0]           opnd_r;
  logic [31:0]           opnd_nxt;
  logic                  ipres_r;
  logic                  ipres_nxt;
  logic                  dpres_r;
  logic                  dpres_nxt;
  logic                  wr_ok;
  cmd_t                  wr_cmd;

  // Transfers are ignored while the core is held
  assign wr_ok  = CP_WR && !CP_STALL;
  assign wr_cmd = wr_ok ? decode(CP_CRN, CP_SEC, CP_OP2) : CMD_NONE;

  always_comb begin
    dfsr_nxt  = dfsr_r;
    pfsr_nxt  = pfsr_r;
    far_nxt   = far_r;
    rdata_nxt = rdata_r;
    // Upper written bits are dropped; only bits 7:0 are stored
    if (wr_ok && CP_CRN == `CRN_FAULT_STATUS) begin
      if (CP_OP2 == `OP2_0) begin
        dfsr_nxt = CP_WDATA[`FST_WIDTH-1:0];
      end else if (CP_OP2 == `OP2_1) begin
        pfsr_nxt = CP_WDATA[`FST_WIDTH-1:0];
      end
    end
    if (wr_ok && CP_CRN == `CRN_FAULT_ADDRESS) begin
      far_nxt = CP_WDATA;
    end
    // A fault in the same cycle as a write wins over the write
    if (DABORT) begin
      dfsr_nxt = {DABORT_DOMAIN, DABORT_TYPE};
      far_nxt  = DABORT_ADDR;
    end
    if (PABORT) begin
      pfsr_nxt = {PABORT_DOMAIN, PABORT_TYPE};
    end
    if (CP_RD && !CP_STALL) begin
      case (CP_CRN)
        `CRN_FAULT_STATUS: begin
          if (CP_OP2 == `OP2_1) begin
            rdata_nxt = {24'h000000, pfsr_r};
          end else begin
            rdata_nxt = {24'h000000, dfsr_r};
          end
        end
        `CRN_FAULT_ADDRESS: rdata_nxt = far_r;
        // Command registers read as zero
        default:            rdata_nxt = `RDATA_RESET;
      endcase
    end
  end

  // ==========================================================
  // Command pulses and operand
  always_comb begin
    cmd_nxt   = wr_cmd;
    opnd_nxt  = opnd_r;
    ipres_nxt = ITLB_FILL && ITLB_PRESERVE_BIT;
    dpres_nxt = DTLB_FILL && DTLB_PRESERVE_BIT;
    if (wr_cmd != CMD_NONE) begin
      // Whole-unit commands expect a zero operand; it is unused
      opnd_nxt = CP_WDATA;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      dfsr_r  <= `FST_RESET;
      pfsr_r  <= `FST_RESET;
      far_r   <= `FADDR_RESET;
      rdata_r <= `RDATA_RESET;
      cmd_r   <= CMD_NONE;
      opnd_r  <= `RDATA_RESET;
      ipres_r <= 1'b0;
      dpres_r <= 1'b0;
    end else if (CE) begin
      dfsr_r  <= dfsr_nxt;
      pfsr_r  <= pfsr_nxt;
      far_r   <= far_nxt;
      rdata_r <= rdata_nxt;
      cmd_r   <= cmd_nxt;
      opnd_r  <= opnd_nxt;
      ipres_r <= ipres_nxt;
      dpres_r <= dpres_nxt;
    end
  end

  // ==========================================================
  // Output decode from the command, operand, read data and preserve registers
  assign CP_RDATA = rdata_r;

  assign ICACHE_INV_ALL   = (cmd_r == CMD_INV_BOTH_CACHE) ||
                            (cmd_r == CMD_INV_ICACHE);
  assign DCACHE_INV_ALL   = (cmd_r == CMD_INV_BOTH_CACHE) ||
                            (cmd_r == CMD_INV_DCACHE);
  assign ICACHE_INV_LINE  = (cmd_r == CMD_INV_ILINE);
  assign DCACHE_INV_LINE  = (cmd_r == CMD_INV_DLINE);
  assign DCACHE_CLEAN     = (cmd_r == CMD_CLEAN_ADDR) ||
                            (cmd_r == CMD_CLEAN_IDX);
  assign DCACHE_CLEAN_INV = (cmd_r == CMD_CLEANINV_ADDR) ||
                            (cmd_r == CMD_CLEANINV_IDX);
  assign ICACHE_PREFETCH  = (cmd_r == CMD_PREFETCH);
  assign LINE_BY_INDEX    = is_index(cmd_r);
  assign LINE_ADDR        = opnd_r;
  assign LINE_INDEX       = opnd_r[IDX_LSB +: IDX_W];
  assign LINE_SEGMENT     = opnd_r[SEG_LSB +: SEG_W];

  assign ITLB_INV_UNPRESERVED = (cmd_r == CMD_INV_BOTH_TLB) ||
                                (cmd_r == CMD_INV_ITLB);
  assign DTLB_INV_UNPRESERVED = (cmd_r == CMD_INV_BOTH_TLB) ||
                                (cmd_r == CMD_INV_DTLB);
  assign ITLB_INV_ADDR = (cmd_r == CMD_INV_ITLB_ADDR);
  assign DTLB_INV_ADDR = (cmd_r == CMD_INV_DTLB_ADDR);

  assign ITLB_FILL_PRESERVED = ipres_r;
  assign DTLB_FILL_PRESERVED = dpres_r;

  // ==========================================================
  // Drain and sleep
  stall_seq u_stall (
    .clk         (MCLK),
    .rst_n       (NRST),
    .ce          (CE),
    .start_drain (cmd_nxt == CMD_DRAIN),
    .start_wait  (cmd_nxt == CMD_WAIT_IRQ),
    .wb_empty    (WB_EMPTY),
    .irq         (irq_sync_r),
    .stall       (CP_STALL),
    .low_power   (LOW_POWER)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  AST_DFSR_ON_ABORT: assert property (
    (CE && DABORT) |=> dfsr_r == {$past(DABORT_DOMAIN), $past(DABORT_TYPE)})
    else $error("data fault status not updated by abort");
  AST_FAR_ON_DABORT: assert property (
    (CE && DABORT) |=> far_r == $past(DABORT_ADDR))
    else $error("fault address not loaded on data abort");
  AST_FAR_KEEPS_ON_PABORT: assert property (
    (CE && PABORT && !DABORT && !(wr_ok && CP_CRN == `CRN_FAULT_ADDRESS))
    |=> $stable(far_r))
    else $error("fault address changed on prefetch abort");
  AST_FAR_RESTORE: assert property (
    (CE && wr_ok && CP_CRN == `CRN_FAULT_ADDRESS && !DABORT)
    |=> far_r == $past(CP_WDATA))
    else $error("fault address write lost");
  AST_FST_READ_UPPER: assert property (
    (CE && CP_RD && !CP_STALL && CP_CRN == `CRN_FAULT_STATUS)
    |=> CP_RDATA[31:8] == 24'h000000)
    else $error("fault status upper bits not zero");
  AST_PFSR_SEPARATE: assert property (
    (CE && PABORT && !DABORT && !wr_ok) |=> $stable(dfsr_r))
    else $error("prefetch abort altered data fault status");
  AST_CMD_READ_ZERO: assert property (
    (CE && CP_RD && !CP_STALL &&
     (CP_CRN == `CRN_CACHE_CMD || CP_CRN == `CRN_TLB_CMD))
    |=> CP_RDATA == 32'h0000_0000)
    else $error("command register read not zero");
  AST_INV_BOTH_CACHE: assert property (
    (CE && wr_ok && CP_CRN == `CRN_CACHE_CMD && CP_SEC == `SEC_C7 &&
     CP_OP2 == `OP2_0) |=> (ICACHE_INV_ALL && DCACHE_INV_ALL))
    else $error("invalidate both caches not issued");
  AST_TLB_ADDR_PULSE: assert property (
    (CE && wr_ok && CP_CRN == `CRN_TLB_CMD && CP_SEC == `SEC_C6 &&
     CP_OP2 == `OP2_1) |=> DTLB_INV_ADDR && LINE_ADDR == $past(CP_WDATA))
    else $error("data TLB single invalidate not issued");
  AST_PRESERVE_MARK: assert property (
    (CE && ITLB_FILL) |=> ITLB_FILL_PRESERVED == $past(ITLB_PRESERVE_BIT))
    else $error("preserve mark wrong on TLB fill");
  AST_DRAIN_STALL: assert property (
    (CE && !CP_STALL && cmd_nxt == CMD_DRAIN) |=> CP_STALL)
    else $error("drain command did not stall");

endmodule

`default_nettype wire

// ### hw/stall_seq.sv
// Stall sequencer for drain-write-buffer and wait-for-interrupt.
// Assumes irq is already synchronised to clk and wb_empty is same-clock.
`timescale 1ns/1ns
`default_nettype none

module stall_seq
  import cpregs_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Requests
  input  wire logic start_drain,
  input  wire logic start_wait,
  // Conditions
  input  wire logic wb_empty,
  input  wire logic irq,
  // Status
  output logic      stall,
  output logic      low_power
);

  stall_state_t state_r;
  stall_state_t state_nxt;

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (start_drain) begin
          state_nxt = ST_DRAIN;
        end else if (start_wait) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_DRAIN: begin
        if (wb_empty) begin
          state_nxt = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (irq) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign stall     = (state_r != ST_RUN);
  assign low_power = (state_r == ST_SLEEP);

  // ==========================================================
  // Checks
  AST_DRAIN_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_DRAIN && !wb_empty) |=> stall)
    else $error("drain stall released before write buffer emptied");
  AST_SLEEP_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    (low_power && irq && ce) |=> !stall)
    else $error("sleep did not end on interrupt");

endmodule

`default_nettype wire

// ### inc/cpregs_defines.svh
// Constants of the fault and maintenance register block.
// Assumes inclusion by bare name from the register block design file.
`ifndef CPREGS_DEFINES_SVH
`define CPREGS_DEFINES_SVH

// ==========================================================
// Primary register numbers
`define CRN_FAULT_STATUS   4'h5
`define CRN_FAULT_ADDRESS  4'h6
`define CRN_CACHE_CMD      4'h7
`define CRN_TLB_CMD        4'h8

// ==========================================================
// Secondary register field values
`define SEC_C0   4'h0
`define SEC_C5   4'h5
`define SEC_C6   4'h6
`define SEC_C7   4'h7
`define SEC_C10  4'hA
`define SEC_C13  4'hD
`define SEC_C14  4'hE

// ==========================================================
// Secondary opcode values
`define OP2_0  3'h0
`define OP2_1  3'h1
`define OP2_2  3'h2
`define OP2_4  3'h4

// ==========================================================
// Fault status layout and reset values
`define FST_DOMAIN_MSB  7
`define FST_DOMAIN_LSB  4
`define FST_TYPE_MSB    3
`define FST_TYPE_LSB    0
`define FST_WIDTH       8
`define FST_RESET       8'h00
`define FADDR_RESET     32'h0000_0000
`define RDATA_RESET     32'h0000_0000

// ==========================================================
// Index operand layout defaults
`define IDX_LSB_DEF  26
`define IDX_W_DEF    6
`define SEG_LSB_DEF  5
`define SEG_W_DEF    3

`endif

// ### inc/cpregs_pkg.sv
// Types shared by the register block and its stall sequencer.
// Assumes cpregs_defines.svh sits on the include path.
`default_nettype none

package cpregs_pkg;

  // ==========================================================
  // Decoded maintenance commands
  typedef enum logic [4:0] {
    CMD_NONE,
    CMD_INV_BOTH_CACHE,
    CMD_INV_ICACHE,
    CMD_INV_DCACHE,
    CMD_INV_ILINE,
    CMD_INV_DLINE,
    CMD_CLEAN_ADDR,
    CMD_CLEAN_IDX,
    CMD_CLEANINV_ADDR,
    CMD_CLEANINV_IDX,
    CMD_PREFETCH,
    CMD_DRAIN,
    CMD_WAIT_IRQ,
    CMD_INV_BOTH_TLB,
    CMD_INV_ITLB,
    CMD_INV_DTLB,
    CMD_INV_ITLB_ADDR,
    CMD_INV_DTLB_ADDR
  } cmd_t;

  // ==========================================================
  // Stall sequencer states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_DRAIN,
    ST_SLEEP
  } stall_state_t;

endpackage

`default_nettype wire

// ### tb/core_model.sv
// Core-side model issuing register transfers to the fault block.
// Assumes the caller keeps requests off stall cycles unless a refusal
// is wanted; every task is entered just after a rising MCLK edge.
`timescale 1ns/1ns
`default_nettype none

module core_model
  import cpregs_pkg::*;
(
  // Clock
  input  wire logic        MCLK,
  // Transfer request
  output logic             CP_WR,
  output logic             CP_RD,
  output logic [3:0]       CP_CRN,
  output logic [3:0]       CP_SEC,
  output logic [2:0]       CP_OP2,
  output logic [31:0]      CP_WDATA,
  // Answer
  input  wire logic [31:0] CP_RDATA
);
  // ==========================================================
  // Bus parking
  initial begin
    CP_WR    = 1'b0;
    CP_RD    = 1'b0;
    CP_CRN   = 4'h0;
    CP_SEC   = 4'h0;
    CP_OP2   = 3'h0;
    CP_WDATA = 32'h0000_0000;
  end

  // Fields flip when idle so no decode can lean on stale values
  task automatic park();
    CP_WR    = 1'b0;
    CP_RD    = 1'b0;
    CP_CRN   = ~CP_CRN;
    CP_SEC   = ~CP_SEC;
    CP_OP2   = ~CP_OP2;
    CP_WDATA = ~CP_WDATA;
  endtask

  // ==========================================================
  // Transfers
  task automatic write(input logic [3:0] crn, input logic [3:0] sec,
                       input logic [2:0] op2, input logic [31:0] data);
    logic [31:0] wd;
    wd = data;
    if (crn == 4'h5) wd[31:8] = 24'h0;
    if ((crn == 4'h7 || crn == 4'h8) &&
        (op2 == 3'h0 || op2 == 3'h4)) wd = 32'h0;
    @(posedge MCLK);
    #1;
    CP_WR    = 1'b1;
    CP_CRN   = crn;
    CP_SEC   = sec;
    CP_OP2   = op2;
    CP_WDATA = wd;
    @(posedge MCLK);
    #1;
    park();
  endtask

  task automatic read(input logic [3:0] crn, input logic [2:0] op2,
                      output logic [31:0] data);
    @(posedge MCLK);
    #1;
    CP_RD  = 1'b1;
    CP_CRN = crn;
    CP_SEC = 4'h0;
    CP_OP2 = op2;
    @(posedge MCLK);
    #1;
    data = CP_RDATA;
    park();
  endtask
endmodule

`default_nettype wire

// ### tb/fault_cache_tlb_ctrl_regs_tb.sv
// Self-checking bench for the fault and maintenance register block.
// Assumes the core model drives the transfer port; the bench drives
// aborts, wake, drain and TLB fill inputs 1 ns after each edge.
`timescale 1ns/1ns
`default_nettype none

module fault_cache_tlb_ctrl_regs_tb
  import cpregs_pkg::*;
;
  logic        MCLK, NRST, CE, IRQ_PIN, WB_EMPTY;
  logic        CP_WR, CP_RD, CP_STALL, LOW_POWER;
  logic [3:0]  CP_CRN, CP_SEC, DABORT_DOMAIN, DABORT_TYPE;
  logic [3:0]  PABORT_DOMAIN, PABORT_TYPE;
  logic [2:0]  CP_OP2;
  logic [31:0] CP_WDATA, CP_RDATA, DABORT_ADDR, LINE_ADDR;
  logic        DABORT, PABORT, ITLB_FILL, DTLB_FILL;
  logic        ITLB_PRESERVE_BIT, DTLB_PRESERVE_BIT;
  logic        ITLB_FILL_PRESERVED, DTLB_FILL_PRESERVED;
  logic [5:0]  LINE_INDEX;
  logic [2:0]  LINE_SEGMENT;
  wire  [11:0] cmd_out;
  int          n_errors;
  int          compares;

  always #5 MCLK = ~MCLK;

  core_model u_core (.MCLK(MCLK), .CP_WR(CP_WR), .CP_RD(CP_RD),
    .CP_CRN(CP_CRN), .CP_SEC(CP_SEC), .CP_OP2(CP_OP2),
    .CP_WDATA(CP_WDATA), .CP_RDATA(CP_RDATA));

  cpregs u_dut (.MCLK(MCLK), .NRST(NRST), .CE(CE), .CP_WR(CP_WR),
    .CP_RD(CP_RD), .CP_CRN(CP_CRN), .CP_SEC(CP_SEC), .CP_OP2(CP_OP2),
    .CP_WDATA(CP_WDATA), .CP_RDATA(CP_RDATA), .CP_STALL(CP_STALL),
    .LOW_POWER(LOW_POWER), .DABORT(DABORT), .DABORT_DOMAIN(DABORT_DOMAIN),
    .DABORT_TYPE(DABORT_TYPE), .DABORT_ADDR(DABORT_ADDR), .PABORT(PABORT),
    .PABORT_DOMAIN(PABORT_DOMAIN), .PABORT_TYPE(PABORT_TYPE),
    .IRQ_PIN(IRQ_PIN), .WB_EMPTY(WB_EMPTY),
    .ICACHE_INV_ALL(cmd_out[11]), .DCACHE_INV_ALL(cmd_out[10]),
    .ICACHE_INV_LINE(cmd_out[9]), .DCACHE_INV_LINE(cmd_out[8]),
    .DCACHE_CLEAN(cmd_out[7]), .DCACHE_CLEAN_INV(cmd_out[6]),
    .ICACHE_PREFETCH(cmd_out[5]), .LINE_BY_INDEX(cmd_out[4]),
    .LINE_ADDR(LINE_ADDR), .LINE_INDEX(LINE_INDEX),
    .LINE_SEGMENT(LINE_SEGMENT), .ITLB_INV_UNPRESERVED(cmd_out[3]),
    .DTLB_INV_UNPRESERVED(cmd_out[2]), .ITLB_INV_ADDR(cmd_out[1]),
    .DTLB_INV_ADDR(cmd_out[0]), .ITLB_FILL(ITLB_FILL),
    .DTLB_FILL(DTLB_FILL), .ITLB_PRESERVE_BIT(ITLB_PRESERVE_BIT),
    .DTLB_PRESERVE_BIT(DTLB_PRESERVE_BIT),
    .ITLB_FILL_PRESERVED(ITLB_FILL_PRESERVED),
    .DTLB_FILL_PRESERVED(DTLB_FILL_PRESERVED));

  // ==========================================================
  // Helpers
  task automatic final_report();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge MCLK);
    #1;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] crn,
                        input logic [2:0] op2, input logic [31:0] exp);
    logic [31:0] v;
    u_core.read(crn, op2, v);
    chk(what, exp, v);
  endtask

  // Bounded wait for the end of a stall or sleep
  task automatic wait_run(input int n);
    int i;
    for (i = 0; i < n && {CP_STALL, LOW_POWER} !== 2'b00; i++) tick();
    chk("run again", 32'h0, {30'h0, CP_STALL, LOW_POWER});
    if ({CP_STALL, LOW_POWER} !== 2'b00) final_report();
  endtask

  // Pulse pattern {crn, sec, op2} should raise
  function automatic logic [11:0] exp_cmd(input logic [10:0] sel);
    case (sel)
      {4'h7, 4'h7, 3'h0}: exp_cmd = 12'hC00;
      {4'h7, 4'h5, 3'h0}: exp_cmd = 12'h800;
      {4'h7, 4'h6, 3'h0}: exp_cmd = 12'h400;
      {4'h7, 4'h5, 3'h1}: exp_cmd = 12'h200;
      {4'h7, 4'h6, 3'h1}: exp_cmd = 12'h100;
      {4'h7, 4'hA, 3'h1}: exp_cmd = 12'h080;
      {4'h7, 4'hA, 3'h2}: exp_cmd = 12'h090;
      {4'h7, 4'hE, 3'h1}: exp_cmd = 12'h040;
      {4'h7, 4'hE, 3'h2}: exp_cmd = 12'h050;
      {4'h7, 4'hD, 3'h1}: exp_cmd = 12'h020;
      {4'h8, 4'h7, 3'h0}: exp_cmd = 12'h00C;
      {4'h8, 4'h5, 3'h0}: exp_cmd = 12'h008;
      {4'h8, 4'h6, 3'h0}: exp_cmd = 12'h004;
      {4'h8, 4'h5, 3'h1}: exp_cmd = 12'h002;
      {4'h8, 4'h6, 3'h1}: exp_cmd = 12'h001;
      default:            exp_cmd = 12'h000;
    endcase
  endfunction

  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge MCLK);
    n_errors++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d, a;
    logic [10:0] sel;
    logic [11:0] e;
    int          k;
    {MCLK, NRST, CE, IRQ_PIN, WB_EMPTY, DABORT, PABORT} = 7'b0010100;
    {DABORT_DOMAIN, DABORT_TYPE, PABORT_DOMAIN, PABORT_TYPE} = 16'h0000;
    DABORT_ADDR = 32'h0000_0000;
    {ITLB_FILL, DTLB_FILL, ITLB_PRESERVE_BIT, DTLB_PRESERVE_BIT} = 4'h0;
    n_errors = 0;
    compares = 0;
    d = $urandom(86);
    repeat (2) @(posedge MCLK);
    #1;
    NRST = 1'b1;
    chk("reset out", 32'h0, {30'h0, CP_STALL, LOW_POWER});
    rd_chk("dfsr reset", 4'h5, 3'h0, 32'h0);
    rd_chk("pfsr reset", 4'h5, 3'h1, 32'h0);
    rd_chk("far reset", 4'h6, 3'h0, 32'h0);
    for (k = 0; k < 4; k++) begin
      a = $urandom;
      u_core.write(4'h6, 4'h0, 3'h0, a);
      rd_chk("far", 4'h6, 3'h0, a);
      d = $urandom;
      u_core.write(4'h5, 4'h0, k[2:0] & 3'h1, d);
      rd_chk("fault status", 4'h5, k[2:0] & 3'h1, {24'h0, d[7:0]});
    end
    CE = 1'b0;
    u_core.write(4'h6, 4'h0, 3'h0, ~a);
    CE = 1'b1;
    rd_chk("far frozen", 4'h6, 3'h0, a);
    for (k = 0; k < 3; k++) begin
      a = $urandom;
      d = $urandom;
      {DABORT, DABORT_DOMAIN, DABORT_TYPE, DABORT_ADDR} = {1'b1, d[7:0], a};
      tick();
      {DABORT, DABORT_DOMAIN, DABORT_TYPE, DABORT_ADDR} = {1'b0, ~d[7:0], ~a};
      rd_chk("dfsr abort", 4'h5, 3'h0, {24'h0, d[7:0]});
      rd_chk("far abort", 4'h6, 3'h0, a);
      {PABORT, PABORT_DOMAIN, PABORT_TYPE} = {1'b1, d[15:8]};
      tick();
      {PABORT, PABORT_DOMAIN, PABORT_TYPE} = {1'b0, ~d[15:8]};
      rd_chk("pfsr abort", 4'h5, 3'h1, {24'h0, d[15:8]});
      rd_chk("dfsr kept", 4'h5, 3'h0, {24'h0, d[7:0]});
      rd_chk("far kept", 4'h6, 3'h0, a);
    end
    for (k = 0; k < 256; k++) begin
      sel = {(k[7] ? 4'h8 : 4'h7), k[6:3], k[2:0]};
      if (sel == {4'h7, 4'hA, 3'h4} || sel == {4'h7, 4'h0, 3'h4}) continue;
      d = $urandom;
      e = exp_cmd(sel);
      u_core.write(sel[10:7], sel[6:3], sel[2:0], d);
      chk("cmd", {20'h0, e}, {20'h0, cmd_out});
      if ((e & 12'h3F3) != 12'h000) chk("operand", d, LINE_ADDR);
      if (e[4]) chk("index", {23'h0, d[31:26], d[7:5]},
                    {23'h0, LINE_INDEX, LINE_SEGMENT});
      tick();
      chk("cmd end", 32'h0, {20'h0, cmd_out});
    end
    rd_chk("cache read", 4'h7, 3'h0, 32'h0);
    rd_chk("tlb read", 4'h8, 3'h0, 32'h0);
    WB_EMPTY = 1'b0;
    u_core.write(4'h7, 4'hA, 3'h4, 32'h0);
    for (k = 0; k < 6; k++) begin
      chk("drain stall", 32'h1, {31'h0, CP_STALL});
      tick();
    end
    u_core.write(4'h6, 4'h0, 3'h0, ~a);
    WB_EMPTY = 1'b1;
    wait_run(4);
    rd_chk("far refused", 4'h6, 3'h0, a);
    IRQ_PIN = 1'b0;
    u_core.write(4'h7, 4'h0, 3'h4, 32'h0);
    for (k = 0; k < 8; k++) begin
      chk("sleep", 32'h3, {30'h0, LOW_POWER, CP_STALL});
      tick();
    end
    IRQ_PIN = 1'b1;
    wait_run(6);
    IRQ_PIN = 1'b0;
    for (k = 0; k < 24; k++) begin
      d = $urandom;
      {ITLB_FILL, ITLB_PRESERVE_BIT, DTLB_FILL, DTLB_PRESERVE_BIT} = d[3:0];
      tick();
      chk("preserve", {30'h0, d[3] & d[2], d[1] & d[0]},
          {30'h0, ITLB_FILL_PRESERVED, DTLB_FILL_PRESERVED});
    end
    final_report();
  end
endmodule

`default_nettype wire
